// ===== hw/mst_top.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module mst_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mst_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [mst_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output var  logic [mst_pkg::DATA_W-1:0]  prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire mst_pkg::mst_hs_t            hs_n_in,
  input  wire logic                        tx_busy,
  input  wire logic                        tx_char_done,
  output var  logic                        tx_halt,
  output var  logic                        modem_irq,
  output var  logic                        irq,
  output var  logic                        terminal_ready_n_out,
  output var  logic                        send_request_n_out,
  output var  logic                        user_output_a_n_out,
  output var  logic                        user_output_b_n_out
);

  mst_pkg::mst_state_t st_r;
  mst_pkg::mst_state_t st_nxt;
  mst_pkg::mst_hs_t    pins_n;

  logic [mst_pkg::HS_W-1:0]  live;
  logic [mst_pkg::HS_W-1:0]  loop_lvl;
  logic [mst_pkg::HS_W-1:0]  chg;
  logic [mst_pkg::INT_W-1:0] int_ev;
  logic [mst_pkg::HS_W-1:0]  int_wide;
  logic                      setup_ph;
  logic                      done_ph;
  logic                      loop_on;
  logic                      halt_want;

  mst_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (hs_n_in),
    .dout    (pins_n)
  );

  // Either edge counts, except call alert: pin rising is status falling
  function automatic logic [mst_pkg::HS_W-1:0] edge_flags(
    input logic [mst_pkg::HS_W-1:0] cur,
    input logic [mst_pkg::HS_W-1:0] prev
  );
    logic [mst_pkg::HS_W-1:0] f;
    f = cur ^ prev;
    f[mst_pkg::HS_ALERT] = prev[mst_pkg::HS_ALERT] &
                           ~cur[mst_pkg::HS_ALERT];
    return f;
  endfunction

  // Sticky update where a new set beats a clear in the same cycle
  function automatic logic [mst_pkg::HS_W-1:0] sticky(
    input logic [mst_pkg::HS_W-1:0] old,
    input logic [mst_pkg::HS_W-1:0] set,
    input logic [mst_pkg::HS_W-1:0] clr
  );
    return (old & ~clr) | set;
  endfunction

  function automatic logic [mst_pkg::DATA_W-1:0] zext8(
    input logic [7:0] v
  );
    return {24'h00_0000, v};
  endfunction

  assign setup_ph = psel & ~penable;
  assign done_ph  = psel & penable & st_r.pready;
  assign loop_on  = st_r.ctrl[mst_pkg::CTL_LOOP];

  assign loop_lvl[mst_pkg::HS_CARRIER] = st_r.ctrl[mst_pkg::CTL_OUT_B];
  assign loop_lvl[mst_pkg::HS_ALERT]   = st_r.ctrl[mst_pkg::CTL_OUT_A];
  assign loop_lvl[mst_pkg::HS_READY]   =
    st_r.ctrl[mst_pkg::CTL_TERM_READY];
  assign loop_lvl[mst_pkg::HS_ACCEPT]  =
    st_r.ctrl[mst_pkg::CTL_SEND_REQ];

  // Pins are active low, so outside loopback the status bit is their complement
  assign live = loop_on ? loop_lvl : ~pins_n;

  // The pipeline is not trusted until both sync stages hold real pin
  // levels; until then the previous value just tracks without flagging
  assign chg = (st_r.phase == mst_pkg::PH_RUN) ?
               edge_flags(live, st_r.prev) : mst_pkg::HS_ZERO;

  // Halt only between characters so a frame is never cut short
  assign halt_want = st_r.ctrl[mst_pkg::CTL_AUTO_FLOW] &
                     ~live[mst_pkg::HS_ACCEPT];

  always_comb begin
    st_nxt = st_r;

    case (st_r.phase)
      mst_pkg::PH_FILL0: begin
        st_nxt.phase = mst_pkg::PH_FILL1;
      end
      mst_pkg::PH_FILL1: begin
        st_nxt.phase = mst_pkg::PH_FILL2;
      end
      // Stage two is real only now, so prev must take one more edge
      mst_pkg::PH_FILL2: begin
        st_nxt.phase = mst_pkg::PH_RUN;
      end
      mst_pkg::PH_RUN: begin
        st_nxt.phase = mst_pkg::PH_RUN;
      end
      default: begin
        st_nxt.phase = mst_pkg::PH_FILL0;
      end
    endcase

    st_nxt.prev = live;

    // Only flags shown by the read are cleared, later ones survive
    st_nxt.flags = sticky(st_r.flags, chg,
                          done_ph ? st_r.rd_flags
                                  : mst_pkg::HS_ZERO);

    if (!halt_want) begin
      st_nxt.halt = 1'b0;
    end else if (!tx_busy || tx_char_done) begin
      st_nxt.halt = 1'b1;
    end

    // Event bits are formed here, after halt, to keep st_nxt loop free
    int_ev[mst_pkg::INT_MODEM] = |chg;
    int_ev[mst_pkg::INT_HALT]  = st_nxt.halt & ~st_r.halt;
    int_wide = sticky({mst_pkg::INT_ZERO, st_r.int_stat},
                      {mst_pkg::INT_ZERO, int_ev},
                      {mst_pkg::INT_ZERO,
                       done_ph ? st_r.rd_int : mst_pkg::INT_ZERO});
    st_nxt.int_stat = int_wide[mst_pkg::INT_W-1:0];

    // Setup cycle: decode, capture read data and the read snapshot
    if (setup_ph) begin
      st_nxt.pready   = 1'b1;
      st_nxt.pslverr  = 1'b0;
      st_nxt.prdata   = '0;
      st_nxt.rd_flags = mst_pkg::HS_ZERO;
      st_nxt.rd_int   = mst_pkg::INT_ZERO;
      if (paddr == mst_pkg::OFS_STATUS) begin
        if (!pwrite) begin
          st_nxt.prdata   = zext8({live, st_r.flags});
          st_nxt.rd_flags = st_r.flags;
        end
      end else if (paddr == mst_pkg::OFS_CONTROL) begin
        if (!pwrite) begin
          st_nxt.prdata = zext8(st_r.ctrl);
        end
      end else if (paddr == mst_pkg::OFS_INT_STAT) begin
        if (!pwrite) begin
          st_nxt.prdata = zext8({6'h00, st_r.int_stat});
          st_nxt.rd_int = st_r.int_stat;
        end
      end else if (paddr == mst_pkg::OFS_INT_MASK) begin
        if (!pwrite) begin
          st_nxt.prdata = zext8({6'h00, st_r.mask});
        end
      end else if (paddr == mst_pkg::OFS_LEVELS) begin
        if (!pwrite) begin
          st_nxt.prdata = zext8({2'h0, tx_busy, st_r.halt, ~pins_n});
        end
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end

    // Access cycle end: writes land here and the answer is withdrawn
    if (done_ph) begin
      st_nxt.pready   = 1'b0;
      st_nxt.pslverr  = 1'b0;
      st_nxt.rd_flags = mst_pkg::HS_ZERO;
      st_nxt.rd_int   = mst_pkg::INT_ZERO;
      if (pwrite && pstrb[0] && !st_r.pslverr) begin
        if (paddr == mst_pkg::OFS_CONTROL) begin
          st_nxt.ctrl = pwdata[7:0] & mst_pkg::CTL_WR_MASK;
        end else if (paddr == mst_pkg::OFS_INT_MASK) begin
          st_nxt.mask = pwdata[mst_pkg::INT_W-1:0];
        end
      end
    end

    st_nxt.msi = |st_nxt.flags;
    st_nxt.irq = |(st_nxt.int_stat & st_nxt.mask);

    // Loopback parks the output pins at their inactive level
    if (st_nxt.ctrl[mst_pkg::CTL_LOOP]) begin
      st_nxt.term_ready_n = 1'b1;
      st_nxt.send_req_n   = 1'b1;
      st_nxt.out_a_n      = 1'b1;
      st_nxt.out_b_n      = 1'b1;
    end else begin
      st_nxt.term_ready_n = ~st_nxt.ctrl[mst_pkg::CTL_TERM_READY];
      st_nxt.send_req_n   = ~st_nxt.ctrl[mst_pkg::CTL_SEND_REQ];
      st_nxt.out_a_n      = ~st_nxt.ctrl[mst_pkg::CTL_OUT_A];
      st_nxt.out_b_n      = ~st_nxt.ctrl[mst_pkg::CTL_OUT_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= mst_pkg::ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata               = st_r.prdata;
  assign pready               = st_r.pready;
  assign pslverr              = st_r.pslverr;
  assign tx_halt              = st_r.halt;
  assign modem_irq            = st_r.msi;
  assign irq                  = st_r.irq;
  assign terminal_ready_n_out = st_r.term_ready_n;
  assign send_request_n_out   = st_r.send_req_n;
  assign user_output_a_n_out  = st_r.out_a_n;
  assign user_output_b_n_out  = st_r.out_b_n;

endmodule

`default_nettype wire

// ===== hw/mst_pkg.sv
package mst_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HS_W   = 4;
  localparam int INT_W  = 2;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LEVELS   = 8'h10;

  // Modem control register fields
  localparam int CTL_TERM_READY = 0;
  localparam int CTL_SEND_REQ   = 1;
  localparam int CTL_OUT_A      = 2;
  localparam int CTL_OUT_B      = 3;
  localparam int CTL_LOOP       = 4;
  localparam int CTL_AUTO_FLOW  = 5;
  localparam logic [7:0] CTL_WR_MASK = 8'h3F;
  localparam logic [7:0] CTL_RESET   = 8'h00;

  // Handshake bit positions, shared by flags and upper status bits
  localparam int HS_ACCEPT  = 0;
  localparam int HS_READY   = 1;
  localparam int HS_ALERT   = 2;
  localparam int HS_CARRIER = 3;
  localparam logic [HS_W-1:0] HS_IDLE_N  = 4'hF;
  localparam logic [HS_W-1:0] HS_ZERO    = 4'h0;

  // Interrupt status bits
  localparam int INT_MODEM = 0;
  localparam int INT_HALT  = 1;
  localparam logic [INT_W-1:0] INT_ZERO = 2'h0;

  // Levels register fields
  localparam int LVL_HALT = 4;
  localparam int LVL_BUSY = 5;

  typedef struct packed {
    logic carrier;
    logic alert;
    logic ready;
    logic accept;
  } mst_hs_t;

  typedef struct packed {
    mst_hs_t stage1;
    mst_hs_t stage2;
  } mst_sync_t;

  localparam mst_sync_t SYNC_RESET = '{stage1: HS_IDLE_N, stage2: HS_IDLE_N};

  typedef enum logic [1:0] {
    PH_FILL0 = 2'b00,
    PH_FILL1 = 2'b01,
    PH_FILL2 = 2'b11,
    PH_RUN   = 2'b10
  } mst_phase_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        ctrl;
    logic [INT_W-1:0]  mask;
    logic [HS_W-1:0]   flags;
    logic [HS_W-1:0]   prev;
    logic [HS_W-1:0]   rd_flags;
    logic [INT_W-1:0]  int_stat;
    logic [INT_W-1:0]  rd_int;
    mst_phase_t        phase;
    logic              halt;
    logic              irq;
    logic              msi;
    logic              term_ready_n;
    logic              send_req_n;
    logic              out_a_n;
    logic              out_b_n;
  } mst_state_t;

  localparam mst_state_t ST_RESET = '{
    prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
    ctrl: CTL_RESET, mask: INT_ZERO, flags: HS_ZERO, prev: HS_ZERO,
    rd_flags: HS_ZERO, int_stat: INT_ZERO, rd_int: INT_ZERO,
    phase: PH_FILL0, halt: 1'b0, irq: 1'b0, msi: 1'b0,
    term_ready_n: 1'b1, send_req_n: 1'b1, out_a_n: 1'b1, out_b_n: 1'b1
  };

endpackage

// ===== hw/mst_sync.sv
`timescale 1ns/100ps
`default_nettype none

module mst_sync (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire mst_pkg::mst_hs_t din,
  output var  mst_pkg::mst_hs_t dout
);

  mst_pkg::mst_sync_t st_r;
  mst_pkg::mst_sync_t st_nxt;

  // Stage one feeds only stage two; nothing else may look at it
  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  // Reset to the idle pin level so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= mst_pkg::SYNC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stage2;

endmodule

`default_nettype wire

// ===== verif/mst_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mst_monitor (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [mst_pkg::ADDR_W-1:0] paddr,
  input wire logic [mst_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire mst_pkg::mst_hs_t           hs_n_in,
  input wire logic                       tx_busy,
  input wire logic                       tx_char_done,
  input wire logic                       tx_halt,
  input wire logic                       modem_irq
);
  mst_pkg::mst_hs_t hs_q;
  logic [3:0]       quiet_r;
  logic             rd_st;
  assign rd_st = psel && penable && pready && !pwrite
                 && paddr == mst_pkg::OFS_STATUS;
  // Cycles since a pin moved or a write; loopback changes come by writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q    <= mst_pkg::HS_IDLE_N;
      quiet_r <= 4'h0;
    end else begin
      hs_q <= hs_n_in;
      if (hs_q != hs_n_in || (psel && pwrite))
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
        quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_single: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  a_err_unmapped: assert property (pslverr |-> pready
    && (paddr[1:0] != 2'h0 || paddr > mst_pkg::OFS_LEVELS))
    else $error("pslverr on a mapped access");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !modem_irq ##1 !modem_irq)
    else $error("modem irq right after reset");
  a_flags_irq: assert property (
    rd_st && !$past(rd_st) && prdata[3:0] != 4'h0 |-> modem_irq)
    else $error("flag set without modem irq");
  a_read_clears: assert property (
    rd_st && quiet_r > 4'h6 |=> !modem_irq)
    else $error("status read left modem irq high");
  a_irq_drop: assert property ($fell(modem_irq) |-> $past(rd_st))
    else $error("modem irq fell without status read");
  a_irq_cause: assert property ($rose(modem_irq) |-> quiet_r < 4'h6)
    else $error("modem irq rose without a change");
  a_halt_char_end: assert property (
    $rose(tx_halt) |-> !$past(tx_busy) || $past(tx_char_done))
    else $error("halt in mid character");
endmodule
bind mst_top mst_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .hs_n_in, .tx_busy, .tx_char_done,
  .tx_halt, .modem_irq);
`default_nettype wire

// ===== verif/mst_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mst_modem_model (
  input  wire logic             pclk,
  input  wire mst_pkg::mst_hs_t want,
  output var  mst_pkg::mst_hs_t pins
);
  // Pins move just after an edge, unrelated to any bus access
  initial pins = mst_pkg::HS_IDLE_N;
  always @(posedge pclk) pins <= want;
endmodule
`default_nettype wire

// ===== verif/modem_status_tracker_bench.sv
`timescale 1ns/100ps
`default_nettype none
module modem_status_tracker_bench;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  mst_pkg::mst_hs_t want, hs_n;
  logic             tx_busy, tx_char_done, tx_halt, modem_irq, irq, err;
  logic [3:0]       old, cur, f;
  wire  [3:0]       n_out;
  int               miscompares = 0;
  int               n_compared = 0;
  int               cycles = 0;
  mst_modem_model peer (.pclk, .want, .pins(hs_n));
  mst_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .hs_n_in(hs_n), .tx_busy,
    .tx_char_done, .tx_halt, .modem_irq, .irq,
    .terminal_ready_n_out(n_out[0]), .send_request_n_out(n_out[1]),
    .user_output_a_n_out(n_out[2]), .user_output_b_n_out(n_out[3]));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", {7'h0, pready}, 8'h01);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic clear_all();
    apb(0, mst_pkg::OFS_STATUS, 0);
    apb(0, mst_pkg::OFS_INT_STAT, 0);
  endtask
  // Alert flags on its pin rising only; the others on either edge
  function automatic logic [3:0] exp_flags(logic [3:0] o, logic [3:0] n);
    return ((o ^ n) & 4'hB) | (~o & n & 4'h4);
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, tx_busy, tx_char_done} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(55));
    want = 4'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, mst_pkg::OFS_STATUS, 0);
    chk("reset status", rd[7:0], {~want, 4'h0});
    $display("test reset done");
    apb(1, mst_pkg::OFS_INT_MASK, 32'h1);
    for (int i = 0; i < 24; i++) begin
      old = want;
      cur = (i < 8) ? old ^ (4'h1 << i[1:0]) : 4'($urandom);
      want <= cur;
      repeat (6) @(posedge pclk);
      f = exp_flags(old, cur);
      chk("modem irq", {7'h0, modem_irq}, {7'h0, |f});
      chk("irq", {7'h0, irq}, {7'h0, |f});
      apb(0, mst_pkg::OFS_STATUS, 0);
      chk("status", rd[7:0], {~cur, f});
      apb(0, mst_pkg::OFS_INT_STAT, 0);
      chk("int status", rd[7:0], {7'h0, |f});
      apb(0, mst_pkg::OFS_STATUS, 0);
      chk("reread", rd[7:0], {~cur, 4'h0});
    end
    $display("test pin changes done");
    apb(1, mst_pkg::OFS_INT_MASK, 32'h0);
    for (int d = 0; d < 4; d++) begin
      want <= want ^ 4'hB;
      repeat (d) @(posedge pclk);
      apb(0, mst_pkg::OFS_STATUS, 0);
      f = rd[3:0];
      repeat (6) @(posedge pclk);
      chk("masked irq", {7'h0, irq}, 8'h00);
      apb(0, mst_pkg::OFS_STATUS, 0);
      chk("flags kept", {4'h0, f | rd[3:0]}, 8'h0B);
    end
    $display("test read collision done");
    for (int c = 0; c < 16; c++) begin
      apb(1, mst_pkg::OFS_CONTROL, 32'h10 | 32'(c));
      repeat (3) @(posedge pclk);
      apb(0, mst_pkg::OFS_STATUS, 0);
      chk("loop status", {4'h0, rd[7:4]},
          {4'h0, c[3], c[2], c[0], c[1]});
      chk("loop pins", {4'h0, n_out}, 8'h0F);
    end
    cur = 4'($urandom);
    apb(1, mst_pkg::OFS_CONTROL, {28'h0, cur});
    apb(0, mst_pkg::OFS_CONTROL, 0);
    chk("control", rd[7:0], {4'h0, cur});
    chk("out pins", {4'h0, n_out}, {4'h0, ~cur});
    $display("test loopback done");
    tx_busy <= 1'b1;
    apb(1, mst_pkg::OFS_CONTROL, 32'hFFFF_FFA0);
    want <= want | 4'h1;
    apb(0, mst_pkg::OFS_CONTROL, 0);
    chk("control", rd[7:0], 8'h20);
    clear_all();
    repeat (6) @(posedge pclk);
    chk("halt busy", {7'h0, tx_halt}, 8'h00);
    tx_char_done <= 1'b1;
    @(posedge pclk);
    tx_char_done <= 1'b0;
    tx_busy <= 1'b0;
    @(posedge pclk);
    chk("halt", {7'h0, tx_halt}, 8'h01);
    want <= want & 4'hE;
    repeat (6) @(posedge pclk);
    chk("halt off", {7'h0, tx_halt}, 8'h00);
    apb(0, mst_pkg::OFS_INT_STAT, 0);
    chk("int events", rd[7:0], 8'h03);
    apb(0, mst_pkg::OFS_LEVELS, 0);
    chk("levels", rd[7:0], {4'h0, ~want});
    $display("test flow done");
    apb(0, 8'h14, 0);
    chk("unmapped err", {7'h0, err}, 8'h01);
    chk("unmapped data", rd[7:0], 8'h00);
    $display("test unmapped done");
    end_sim();
  end
endmodule
`default_nettype wire
